// ---- hw/pixel_fifo.v ----
// Small flip-flop FIFO for the generated pixel words.
// Assumes one clock; both sides use valid/ready handshakes.
`timescale 1ns/1ns
`default_nettype none
module pixel_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_clock,
  input  wire             i_reset_n,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire [AW:0]      o_count
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_q];
  assign o_count     = cnt_q;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // pixel_fifo
`default_nettype wire

// ---- hw/pixgen_defines.vh ----
// Constants for the synthetic pixel generator: register indexes, field
// positions, reset values and timing units.
// Assumes a 50 MHz system clock; byte address of a register is 4 x index.
`ifndef PIXGEN_DEFINES_VH
`define PIXGEN_DEFINES_VH

`define PG_IDX_ROWS      12'h2d0
`define PG_IDX_COLS      12'h2d1
`define PG_IDX_SPACING   12'h2d2
`define PG_IDX_PPB       12'h2d3
`define PG_IDX_DELAY     12'h2d4
`define PG_IDX_INTEG     12'h2d5
`define PG_IDX_FOWLER    12'h2d6
`define PG_IDX_MASK      12'h2d7
`define PG_IDX_CTRL      12'h2fc
`define PG_IDX_STATUS    12'h2fd

`define PG_MODE_HI       15
`define PG_MODE_LO       13
`define PG_NOISE_BIT     15

`define PG_CTRL_RESET    16'h0000
`define PG_CFG16_RESET   16'h0000
`define PG_CFG8_RESET    8'h00
`define PG_LFSR_SEED     8'h01

`define PG_RESP_OKAY     2'b00
`define PG_RESP_SLVERR   2'b10

`define PG_CLK_MHZ       50
`define PG_SPACING_NS    100
`define PG_SPACING_CYC   ((`PG_SPACING_NS * `PG_CLK_MHZ) / 1000)
`define PG_DELAY_MS      1
`define PG_MS_CYC        (`PG_DELAY_MS * `PG_CLK_MHZ * 1000)

`define PG_FIFO_DEPTH    8
`define PG_PIX_WIDTH     16

`endif

// ---- hw/synth_pixel_gen.v ----
// Synthetic pixel generator with an AXI4-Lite register slave.
// Assumes start exposure is a one-cycle pulse and the slot bus inputs are
// synchronous to i_clock.
// Overview of operation
// - Mode field at control bits 15:13
// - Modes 0 and 4 idle; reset 0
// - Mode decodes kind; bit 2 selects noise
// - Frame modes start on start exposure
// - Rows times columns bursts, spaced 100 ns units
// - Each burst holds pixels-per-burst pixels
// - Word is channel id plus data byte
// - Visible: wait delay milliseconds before first burst
// - Infrared: sample frames, each after delay
// - Integration wait, then identical second readout
// - Replacement injects only in masked slots
// - Mask bit n is slot n; slot 0 never
// - Configuration registers at indexes 2D0 to 2D7
// - Own slot starts after previous slot ends
// - Replacement slot carries pixels-per-burst pixels
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pixgen_defines.vh"
module synth_pixel_gen #(
  parameter MS_CYCLES = `PG_MS_CYC,
  parameter AW        = 16
) (
  input  wire          i_clock,
  input  wire          i_reset_n,
  input  wire [AW-1:0] i_s_axi_awaddr,
  input  wire          i_s_axi_awvalid,
  output wire          o_s_axi_awready,
  input  wire [31:0]   i_s_axi_wdata,
  input  wire [3:0]    i_s_axi_wstrb,
  input  wire          i_s_axi_wvalid,
  output wire          o_s_axi_wready,
  output wire [1:0]    o_s_axi_bresp,
  output wire          o_s_axi_bvalid,
  input  wire          i_s_axi_bready,
  input  wire [AW-1:0] i_s_axi_araddr,
  input  wire          i_s_axi_arvalid,
  output wire          o_s_axi_arready,
  output wire [31:0]   o_s_axi_rdata,
  output wire [1:0]    o_s_axi_rresp,
  output wire          o_s_axi_rvalid,
  input  wire          i_s_axi_rready,
  input  wire          i_start_exposure,
  input  wire          i_slot_busy,
  input  wire [2:0]    i_slot_priority,
  output wire          o_slot_active,
  output wire [2:0]    o_slot_priority,
  output wire          o_pix_valid,
  input  wire          i_pix_ready,
  output wire [15:0]   o_pix_data
);
  localparam S_IDLE  = 3'd0;
  localparam S_DELAY = 3'd1;
  localparam S_BURST = 3'd2;
  localparam S_GAP   = 3'd3;
  localparam S_INTEG = 3'd4;
  localparam S_SLOT  = 3'd5;

  localparam [31:0] GAP_CYC = `PG_SPACING_CYC;
  localparam [31:0] MS_CYC  = MS_CYCLES;

  function hit;
    input [AW-1:0] addr;
    input [11:0]   idx;
    begin
      hit = (addr[AW-1:2] == {{(AW-14){1'b0}}, idx});
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  st;
    begin
      merge16 = {st[1] ? wd[15:8] : old[15:8],
                 st[0] ? wd[7:0]  : old[7:0]};
    end
  endfunction

  // Next slot after prio is usable only if it does not wrap to 0
  function slot_ok;
    input [7:0] mask;
    input [2:0] prio;
    reg   [2:0] nxt;
    begin
      nxt     = prio + 3'd1;
      slot_ok = (nxt != 3'd0) && mask[nxt];
    end
  endfunction

  reg [15:0] rows_q;
  reg [15:0] cols_q;
  reg [7:0]  spacing_q;
  reg [7:0]  ppb_q;
  reg [7:0]  delay_q;
  reg [15:0] integ_q;
  reg [7:0]  fowler_q;
  reg [7:0]  mask_q;
  reg [15:0] ctrl_q;

  reg          aw_hold_q;
  reg [AW-1:0] awaddr_q;
  reg          w_hold_q;
  reg [31:0]   wdata_q;
  reg [3:0]    wstrb_q;
  reg          bvalid_q;
  reg [1:0]    bresp_q;
  reg          rvalid_q;
  reg [31:0]   rdata_q;
  reg [1:0]    rresp_q;
  reg [31:0]   rd_d;
  reg          rd_ok_d;
  reg          wr_ok;

  reg [2:0]  state_q;
  reg [31:0] burst_left_q;
  reg [7:0]  pix_cnt_q;
  reg [7:0]  frame_q;
  reg        phase_q;
  reg [7:0]  incr_q;
  reg [7:0]  lfsr_q;
  reg [2:0]  slot_q;
  reg [15:0] wait_q;
  reg [31:0] pre_q;
  reg        prev_busy_q;
  reg [2:0]  prev_prio_q;

  wire [2:0]  mode;
  wire        noise;
  wire        vis_mode;
  wire        ir_mode;
  wire        rep_mode;
  wire        gen_on;
  wire        slot_end;
  wire        burst_full;
  wire        last_burst;
  wire        push;
  wire        fifo_ready;
  wire [15:0] pix_word;
  wire [31:0] unit_len;
  wire        wait_done;
  wire [3:0]  fifo_count;
  wire        do_write;

  assign mode     = ctrl_q[`PG_MODE_HI:`PG_MODE_LO];
  assign noise    = ctrl_q[`PG_NOISE_BIT];
  assign gen_on   = (mode[1:0] != 2'b00);
  assign vis_mode = (mode[1:0] == 2'b01);
  assign ir_mode  = (mode[1:0] == 2'b10);
  assign rep_mode = (mode[1:0] == 2'b11);

  // Bus slave: address and data may arrive in either order
  assign o_s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign o_s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = ~rvalid_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
  assign do_write        = aw_hold_q & w_hold_q & ~bvalid_q;

  always @* begin
    wr_ok = 1'b1;
    if (!(hit(awaddr_q, `PG_IDX_ROWS) || hit(awaddr_q, `PG_IDX_COLS) ||
          hit(awaddr_q, `PG_IDX_SPACING) || hit(awaddr_q, `PG_IDX_PPB) ||
          hit(awaddr_q, `PG_IDX_DELAY) || hit(awaddr_q, `PG_IDX_INTEG) ||
          hit(awaddr_q, `PG_IDX_FOWLER) || hit(awaddr_q, `PG_IDX_MASK) ||
          hit(awaddr_q, `PG_IDX_CTRL))) begin
      wr_ok = 1'b0;
    end
  end

  always @* begin
    rd_d    = 32'h0000_0000;
    rd_ok_d = 1'b1;
    if (hit(i_s_axi_araddr, `PG_IDX_ROWS)) begin
      rd_d = {16'h0000, rows_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_COLS)) begin
      rd_d = {16'h0000, cols_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_SPACING)) begin
      rd_d = {24'h000000, spacing_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_PPB)) begin
      rd_d = {24'h000000, ppb_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_DELAY)) begin
      rd_d = {24'h000000, delay_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_INTEG)) begin
      rd_d = {16'h0000, integ_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_FOWLER)) begin
      rd_d = {24'h000000, fowler_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_MASK)) begin
      rd_d = {24'h000000, mask_q};
    end else if (hit(i_s_axi_araddr, `PG_IDX_CTRL)) begin
      rd_d = {16'h0000, ctrl_q[15:13], 13'h0000};
    end else if (hit(i_s_axi_araddr, `PG_IDX_STATUS)) begin
      rd_d = {16'h0000, frame_q, fifo_count, phase_q, state_q};
    end else begin
      rd_ok_d = 1'b0;
    end
  end

  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= {AW{1'b0}};
      w_hold_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PG_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `PG_RESP_OKAY;
      rows_q    <= `PG_CFG16_RESET;
      cols_q    <= `PG_CFG16_RESET;
      spacing_q <= `PG_CFG8_RESET;
      ppb_q     <= `PG_CFG8_RESET;
      delay_q   <= `PG_CFG8_RESET;
      integ_q   <= `PG_CFG16_RESET;
      fowler_q  <= `PG_CFG8_RESET;
      mask_q    <= `PG_CFG8_RESET;
      ctrl_q    <= `PG_CTRL_RESET;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `PG_RESP_OKAY : `PG_RESP_SLVERR;
        if (hit(awaddr_q, `PG_IDX_ROWS)) begin
          rows_q <= merge16(rows_q, wdata_q, wstrb_q);
        end
        if (hit(awaddr_q, `PG_IDX_COLS)) begin
          cols_q <= merge16(cols_q, wdata_q, wstrb_q);
        end
        if (hit(awaddr_q, `PG_IDX_SPACING) && wstrb_q[0]) begin
          spacing_q <= wdata_q[7:0];
        end
        if (hit(awaddr_q, `PG_IDX_PPB) && wstrb_q[0]) begin
          ppb_q <= wdata_q[7:0];
        end
        if (hit(awaddr_q, `PG_IDX_DELAY) && wstrb_q[0]) begin
          delay_q <= wdata_q[7:0];
        end
        if (hit(awaddr_q, `PG_IDX_INTEG)) begin
          integ_q <= merge16(integ_q, wdata_q, wstrb_q);
        end
        if (hit(awaddr_q, `PG_IDX_FOWLER) && wstrb_q[0]) begin
          fowler_q <= wdata_q[7:0];
        end
        if (hit(awaddr_q, `PG_IDX_MASK) && wstrb_q[0]) begin
          mask_q <= wdata_q[7:0];
        end
        if (hit(awaddr_q, `PG_IDX_CTRL)) begin
          ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q);
        end
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_d;
        rresp_q  <= rd_ok_d ? `PG_RESP_OKAY : `PG_RESP_SLVERR;
      end else if (rvalid_q && i_s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Generator datapath
  assign burst_full = (pix_cnt_q == ppb_q);
  assign last_burst = (burst_left_q == 32'd0) ||
                      (burst_full && burst_left_q == 32'd1);
  assign pix_word   = {pix_cnt_q, noise ? lfsr_q : incr_q};
  assign push       = ((state_q == S_BURST && burst_left_q != 32'd0) ||
                       state_q == S_SLOT) && !burst_full && fifo_ready;
  assign unit_len   = (state_q == S_GAP) ? GAP_CYC : MS_CYC;
  assign wait_done  = (wait_q == 16'h0000);
  assign slot_end   = prev_busy_q & ~i_slot_busy;
  assign o_slot_active   = (state_q == S_SLOT);
  assign o_slot_priority = slot_q;

  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_q      <= S_IDLE;
      burst_left_q <= 32'd0;
      pix_cnt_q    <= 8'h00;
      frame_q      <= 8'h00;
      phase_q      <= 1'b0;
      incr_q       <= 8'h00;
      lfsr_q       <= `PG_LFSR_SEED;
      slot_q       <= 3'd0;
      wait_q       <= 16'h0000;
      pre_q        <= 32'd0;
      prev_busy_q  <= 1'b0;
      prev_prio_q  <= 3'd0;
    end else begin
      prev_busy_q <= i_slot_busy;
      if (i_slot_busy) begin
        prev_prio_q <= i_slot_priority;
      end
      if (push) begin
        pix_cnt_q <= pix_cnt_q + 8'h01;
        incr_q    <= incr_q + 8'h01;
        lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      end
      if (!wait_done) begin
        if (pre_q == unit_len - 32'd1) begin
          pre_q  <= 32'd0;
          wait_q <= wait_q - 16'h0001;
        end else begin
          pre_q <= pre_q + 32'd1;
        end
      end
      case (state_q)
        S_IDLE: begin
          if ((vis_mode || ir_mode) && i_start_exposure) begin
            phase_q <= 1'b0;
            frame_q <= 8'h00;
            wait_q  <= {8'h00, delay_q};
            pre_q   <= 32'd0;
            state_q <= S_DELAY;
          end else if (rep_mode && slot_end && slot_ok(mask_q, prev_prio_q)) begin
            slot_q    <= prev_prio_q + 3'd1;
            pix_cnt_q <= 8'h00;
            state_q   <= S_SLOT;
          end
        end
        S_DELAY: begin
          if (wait_done) begin
            burst_left_q <= rows_q * cols_q;
            pix_cnt_q    <= 8'h00;
            state_q      <= S_BURST;
          end
        end
        S_BURST: begin
          if (last_burst) begin
            burst_left_q <= 32'd0;
            if (ir_mode && ({1'b0, frame_q} + 9'd1 < {1'b0, fowler_q})) begin
              frame_q <= frame_q + 8'h01;
              wait_q  <= {8'h00, delay_q};
              pre_q   <= 32'd0;
              state_q <= S_DELAY;
            end else if (ir_mode && !phase_q) begin
              phase_q <= 1'b1;
              frame_q <= 8'h00;
              wait_q  <= integ_q;
              pre_q   <= 32'd0;
              state_q <= S_INTEG;
            end else begin
              state_q <= S_IDLE;
            end
          end else if (burst_full) begin
            burst_left_q <= burst_left_q - 32'd1;
            wait_q       <= {8'h00, spacing_q};
            pre_q        <= 32'd0;
            state_q      <= S_GAP;
          end
        end
        S_GAP: begin
          if (wait_done) begin
            pix_cnt_q <= 8'h00;
            state_q   <= S_BURST;
          end
        end
        S_INTEG: begin
          // Second readout starts with the same per-frame delay
          if (wait_done) begin
            wait_q  <= {8'h00, delay_q};
            pre_q   <= 32'd0;
            state_q <= S_DELAY;
          end
        end
        S_SLOT: begin
          if (burst_full) begin
            // Our own slot end may trigger the next masked slot directly
            if (slot_ok(mask_q, slot_q)) begin
              slot_q    <= slot_q + 3'd1;
              pix_cnt_q <= 8'h00;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // Clearing the mode aborts any run in progress
      if (!gen_on) begin
        state_q <= S_IDLE;
        wait_q  <= 16'h0000;
      end
    end
  end

  pixel_fifo #(
    .WIDTH (`PG_PIX_WIDTH),
    .DEPTH (`PG_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (pix_word),
    .o_out_valid (o_pix_valid),
    .i_out_ready (i_pix_ready),
    .o_out_data  (o_pix_data),
    .o_count     (fifo_count)
  );
endmodule // synth_pixel_gen
`default_nettype wire

// ---- tb/pixel_sink.sv ----
// Behavioural host sink that takes the generated pixel stream.
// Assumes the bench picks the pacing: 0 always ready, 1 random stalls, 2 stalled.
`timescale 1ns/1ns
`default_nettype none
module pixel_sink (
  input wire logic       i_clock,
  input wire logic [1:0] i_mode,
  output logic           o_pix_ready
);
  initial o_pix_ready = 1'b0;
  // A stalled host makes the generator fill its buffer and then wait
  always @(posedge i_clock) begin
    o_pix_ready <= (i_mode == 2'd0) || (i_mode == 2'd1 && $urandom_range(3, 0) != 0);
  end
endmodule // pixel_sink
`default_nettype wire

// ---- tb/pixgen_props.sv ----
// Assertion checker for synth_pixel_gen: register bus, pixel stream, slots.
// Bound to every synth_pixel_gen instance; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pixgen_props (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic        i_slot_busy,
  input wire logic        o_slot_active,
  input wire logic [2:0]  o_slot_priority,
  input wire logic        o_pix_valid,
  input wire logic        i_pix_ready,
  input wire logic [15:0] o_pix_data
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // The bench master holds bready and rready up, so a stalled response never occurs
  a_bresp_single: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_single: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read answer repeated");
  a_write_refused: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##[1:2] o_s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_pix_stands: assert property (o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data))
    else $error("pixel changed while stalled");
  a_slot_nonzero: assert property (o_slot_active |-> o_slot_priority != 3'h0)
    else $error("slot zero emulated");
  a_slot_after_end: assert property ($rose(o_slot_active) |-> !i_slot_busy)
    else $error("own slot began during a busy slot");
  a_idle_after_reset: assert property ($rose(i_reset_n) |-> !o_pix_valid && !o_slot_active && !o_s_axi_bvalid)
    else $error("not idle after reset");
  c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
  c_pixel: cover property (o_pix_valid && i_pix_ready);
  c_slot: cover property ($rose(o_slot_active));
endmodule // pixgen_props
bind synth_pixel_gen pixgen_props chk_u (.i_clock, .i_reset_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .i_slot_busy, .o_slot_active, .o_slot_priority,
  .o_pix_valid, .i_pix_ready, .o_pix_data);
`default_nettype wire

// ---- tb/synth_pixel_gen_bench.sv ----
// Self-checking bench for synth_pixel_gen: registers, frame modes, slots, buffer.
// Assumes a millisecond shortened to MS clocks through MS_CYCLES.
`timescale 1ns/1ns
`default_nettype none
`include "pixgen_defines.vh"
module synth_pixel_gen_bench;
  localparam int MS = 20;
  localparam logic [11:0] IDX [9] = '{`PG_IDX_ROWS, `PG_IDX_COLS, `PG_IDX_SPACING, `PG_IDX_PPB, `PG_IDX_DELAY,
                                      `PG_IDX_INTEG, `PG_IDX_FOWLER, `PG_IDX_MASK, `PG_IDX_CTRL};
  localparam logic [31:0] MSK [9] = '{32'hffff, 32'hffff, 32'hff, 32'hff, 32'hff, 32'hffff, 32'hff, 32'hff, 32'he000};
  logic        i_clock = 1'b0, i_reset_n = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
  logic        i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic        i_start_exposure = 1'b0, i_slot_busy = 1'b0, sa_q = 1'b0;
  logic [15:0] i_s_axi_awaddr = 16'h0, i_s_axi_araddr = 16'h0;
  logic [31:0] i_s_axi_wdata = 32'h0, rd, cv [8];
  logic [3:0]  i_s_axi_wstrb = 4'hf;
  logic [2:0]  i_slot_priority = 3'h0;
  logic [1:0]  smode = 2'd0, rs;
  wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire         o_slot_active, o_pix_valid, i_pix_ready;
  wire [1:0]   o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0]  o_s_axi_rdata;
  wire [2:0]   o_slot_priority;
  wire [15:0]  o_pix_data;
  int          fail_count = 0, compares = 0, cyc = 0, t0 = 0;
  logic [15:0] q [$];
  int          ts [$];
  logic [2:0]  sp [$];

  synth_pixel_gen #(.MS_CYCLES(MS)) dut_u (.i_clock, .i_reset_n, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_start_exposure, .i_slot_busy, .i_slot_priority,
    .o_slot_active, .o_slot_priority, .o_pix_valid, .i_pix_ready, .o_pix_data);
  pixel_sink sink_u (.i_clock(i_clock), .i_mode(smode), .o_pix_ready(i_pix_ready));

  always #10 i_clock = ~i_clock;

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Records every word the host takes and the first slot number of each run of owned slots
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    sa_q <= o_slot_active;
    if (o_pix_valid === 1'b1 && i_pix_ready === 1'b1) begin
      q.push_back(o_pix_data);
      ts.push_back(cyc);
    end
    if (o_slot_active === 1'b1 && sa_q !== 1'b1) sp.push_back(o_slot_priority);
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    @(posedge i_clock);
    i_s_axi_awaddr <= {2'b00, idx, 2'b00};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid !== 1'b1);
    rs = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] idx);
    @(posedge i_clock);
    i_s_axi_araddr <= {2'b00, idx, 2'b00};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid !== 1'b1);
    rd = o_s_axi_rdata;
    rs = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask

  task automatic setup(input logic [2:0] m);
    foreach (cv[i]) wr(IDX[i], cv[i]);
    wr(`PG_IDX_CTRL, {16'h0, m, 13'h0});
    q.delete();
    ts.delete();
    sp.delete();
  endtask

  // Idle state and empty buffer both, so every word has reached the host
  task automatic wait_idle();
    do rd_reg(`PG_IDX_STATUS);
    while ({rd[7:4], rd[2:0]} !== 7'h0);
  endtask

  task automatic pulse();
    @(posedge i_clock);
    i_start_exposure <= 1'b1;
    t0 = cyc;
    @(posedge i_clock);
    i_start_exposure <= 1'b0;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic int expn(input logic [2:0] m, input int rcp, input int f);
    if (m[1:0] == 2'd1) return rcp;
    if (m[1:0] == 2'd2) return 2 * rcp * (f == 0 ? 1 : f);
    return 0;
  endfunction

  // Burst gaps are only meaningful while the host never stalls; a frame start
  // follows the per-frame delay rather than the burst spacing
  task automatic check_stream(input int p, input logic noise, input int n, input int gap, input int b, input int fg);
    check(q.size(), n);
    for (int i = 1; i < q.size(); i++) begin
      check(q[i][7:0], noise ? lfsr(q[i-1][7:0]) : 8'(q[i-1][7:0] + 8'h1));
      if (i % p == 0) check(ts[i] - ts[i-1] >= ((i / p) % b != 0 ? gap : fg), 1);
    end
    foreach (q[i]) check(q[i][15:8], i % p);
  endtask

  initial begin
    int r, c, p, f, dl, sg;
    r = $urandom(98644);
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    foreach (IDX[i]) begin
      rd_reg(IDX[i]);
      check(rd, 32'h0);
    end
    foreach (IDX[i]) begin
      cv[0] = $urandom();
      if (i == 8) cv[0][15:13] = 3'h0;
      wr(IDX[i], cv[0]);
      check(rs, `PG_RESP_OKAY);
      rd_reg(IDX[i]);
      check(rd, cv[0] & MSK[i]);
    end
    wr(`PG_IDX_CTRL, 32'h9fff);
    rd_reg(`PG_IDX_CTRL);
    check(rd, 32'h8000);
    wr(12'h2e0, 32'h1);
    check(rs, `PG_RESP_SLVERR);
    rd_reg(12'h2e0);
    check(rs, `PG_RESP_SLVERR);
    check(rd, 32'h0);
    for (int m = 0; m < 8; m++) begin
      r = $urandom_range(2, 1);
      c = $urandom_range(3, 1);
      p = $urandom_range(5, 2);
      f = $urandom_range(2, 0);
      dl = $urandom_range(2, 0);
      sg = $urandom_range(3, 1);
      cv = '{r, c, sg, p, dl, 1, f, 0};
      setup(m[2:0]);
      pulse();
      wait_idle();
      check_stream(p, m[2], expn(m[2:0], r * c * p, f), sg * 5, r * c, dl * MS);
      if (q.size() > 0) check(ts[0] - t0 >= dl * MS, 1);
    end
    cv = '{1, 1, 1, 12, 0, 1, 1, 0};
    smode <= 2'd2;
    setup(3'h1);
    pulse();
    repeat (40) @(posedge i_clock);
    rd_reg(`PG_IDX_STATUS);
    check(rd[7:4], 4'h8);
    check(o_pix_valid, 1'b1);
    smode <= 2'd1;
    wait_idle();
    check_stream(12, 1'b0, 12, 0, 1, 0);
    cv = '{1, 1, 1, 2, 0, 1, 1, 8'h8f};
    smode <= 2'd0;
    setup(3'h7);
    foreach (cv[i]) begin
      if (i < 4) begin
        @(posedge i_clock);
        i_slot_busy <= 1'b1;
        i_slot_priority <= i == 0 ? 3'h0 : i == 1 ? 3'h6 : i == 2 ? 3'h7 : 3'h4;
        repeat (3) @(posedge i_clock);
        i_slot_busy <= 1'b0;
        repeat (15) @(posedge i_clock);
      end
    end
    wait_idle();
    check_stream(2, 1'b1, 8, 0, 1, 0);
    check(sp.size(), 2);
    check(sp[0], 3'h1);
    check(sp[1], 3'h7);
    end_sim();
  end
endmodule // synth_pixel_gen_bench
`default_nettype wire
